// File: design/tsc_top.sv
// Purpose: Control and protection logic of one converter supply section
// Assumes: mclk 25 MHz; analog sensors give level indications
// Notes:   Analog regulator, step-up and detector front end live outside
`timescale 1ns/1ns
`include "tsc_params.svh"
module tsc_top
	import tsc_pkg::*;
#(
	parameter int OFF_CYCLES = `TSC_OFF_CYCLES,
	parameter int ON_RATIO   = `TSC_ON_OFF_RATIO,
	parameter int TONE_HALF  = `TSC_TONE_HALF
)
(
	// Clock and reset
	input  wire logic        mclk,
	input  wire logic        rst_n,
	// Serial bus
	input  wire logic        scl_in,
	input  wire logic        sda_in,
	output logic             sda_out,
	output logic             sda_oe,
	// Tone keying and detection
	input  wire logic        tone_key_in,
	input  wire logic        tone_detect_in,
	input  wire logic        external_modulation_in,
	output logic             tone_out,
	output logic             tone_detect_out,
	output logic             tone_detect_oe,
	// Analog indications
	input  wire logic        overload_in,
	input  wire logic        overtemp_in,
	input  wire logic        undervoltage_in,
	// Power block controls
	output tsc_power_t       power,
	output logic             ext_mod_route,
	output logic [7:0]       system_control_register
);

	localparam int ON_CYCLES = OFF_CYCLES / ON_RATIO;

	// Timer is 32 bits and tone counter 16 bits wide
	initial begin
		if (OFF_CYCLES < ON_RATIO || ON_RATIO < 1 || TONE_HALF < 1)
			$error("tsc_top: bad timing parameters");
		if (TONE_HALF > 65535)
			$error("tsc_top: tone half period too long");
	end

	// Shared by both protection intervals
	function automatic logic [31:0] tick(input logic [31:0] t);
		tick = t + 32'h1;
	endfunction

	function automatic logic done(input logic [31:0] t, input int lim);
		done = (t >= 32'(lim - 1));
	endfunction

	// Two-stage synchronisers for every outside level
	logic [6:0] sync1;
	logic [6:0] sync2;
	logic       scl_s;
	logic       sda_s;
	logic       key_s;
	logic       det_s;
	logic       ovl_s;
	logic       ovt_s;
	logic       uvl_s;

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			sync1 <= 7'h03;
			sync2 <= 7'h03;
		end else begin
			sync1 <= {undervoltage_in, overtemp_in, overload_in, tone_detect_in,
				tone_key_in, sda_in, scl_in};
			sync2 <= sync1;
		end
	end
	assign {uvl_s, ovt_s, ovl_s, det_s, key_s, sda_s, scl_s} = sync2;

	// Register port
	logic       wr_stb;
	logic [7:0] wr_data;
	logic       slave_oe;
	tsc_ctrl_t  ctrl;
	tsc_ctrl_t  next_ctrl;
	tsc_diag_t  diag;
	tsc_diag_t  next_diag;

	tsc_i2c_slave u_slave (
		.mclk    (mclk),
		.rst_n   (rst_n),
		.scl     (scl_s),
		.sda     (sda_s),
		.lockout (uvl_s),
		.sda_oe  (slave_oe),
		.rd_data ({ctrl, diag}),
		.wr_stb  (wr_stb),
		.wr_data (wr_data)
	);

	// Control bits; lockout acts as a reset of the control bits
	always_comb begin
		next_ctrl = ctrl;
		if (uvl_s)
			next_ctrl = `TSC_CTRL_RESET;
		else if (wr_stb)
			next_ctrl = wr_data[7:2];
	end

	// Protection timer
	tsc_prot_t prot;
	tsc_prot_t next_prot;
	logic [31:0] tmr;
	logic [31:0] next_tmr;
	logic        on_seen;
	logic        next_on_seen;

	always_comb begin
		next_prot    = prot;
		next_tmr     = tmr;
		next_on_seen = on_seen;
		next_diag    = diag;
		next_diag.overtemp_flag = ovt_s;
		if (!ctrl.enable || uvl_s) begin
			next_prot = TSC_PROT_NORMAL;
			next_diag.overload_flag = 1'b0;
		end else if (ctrl.pulsed_limit_select) begin
			next_prot = TSC_PROT_NORMAL;
			next_diag.overload_flag = ovl_s;
		end else begin
			case (prot)
			TSC_PROT_NORMAL: begin
				if (ovl_s) begin
					next_prot = TSC_PROT_OFF;
					next_tmr  = 32'h0;
					next_diag.overload_flag = 1'b1;
				end
			end
			TSC_PROT_OFF: begin
				next_tmr = tick(tmr);
				if (done(tmr, OFF_CYCLES)) begin
					next_prot    = TSC_PROT_ON;
					next_tmr     = 32'h0;
					next_on_seen = 1'b0;
				end
			end
			TSC_PROT_ON: begin
				next_tmr = tick(tmr);
				if (ovl_s)
					next_on_seen = 1'b1;
				if (done(tmr, ON_CYCLES)) begin
					next_tmr = 32'h0;
					if (ovl_s || on_seen) begin
						next_prot = TSC_PROT_OFF;
					end else begin
						next_prot = TSC_PROT_NORMAL;
						next_diag.overload_flag = 1'b0;
					end
				end
			end
			default: next_prot = TSC_PROT_NORMAL;
			endcase
		end
	end

	// Tone generator, gated by force bit or synchronised key pin
	logic [15:0] tone_cnt;
	logic [15:0] next_tone_cnt;
	logic        tone_ph;
	logic        next_tone_ph;
	logic        run;
	logic        tone_gate;
	logic        out_en;
	tsc_power_t  next_power;
	logic        next_tone_out;
	logic        next_det_oe;
	logic        next_route;
	logic [7:0]  next_scr;

	assign run       = ctrl.enable && !diag.overtemp_flag && !uvl_s;
	assign out_en    = run && prot != TSC_PROT_OFF;
	assign tone_gate = ctrl.tone_force_on | key_s;

	always_comb begin
		next_tone_cnt = tone_cnt + 16'h1;
		next_tone_ph  = tone_ph;
		if (tone_cnt >= 16'(TONE_HALF - 1)) begin
			next_tone_cnt = 16'h0;
			next_tone_ph  = ~tone_ph;
		end
	end

	// Level fields follow run so a standby section shows no live setting
	always_comb begin
		next_power.tx_output_path = out_en & ctrl.tx_path_select;
		next_power.rx_output_path = out_en & ~ctrl.tx_path_select;
		next_power.converter_on   = run;
		next_power.regulator_on   = out_en;
		next_power.level_high     = run & ctrl.voltage_level_select;
		next_power.comp_on        = run & ctrl.line_drop_compensation;
		next_power.comp_big_step  = run & ctrl.line_drop_compensation &
			ctrl.voltage_level_select;
		// Force bit wins over key pin, so keying needs it low
		next_tone_out = out_en & tone_gate & tone_ph;
		next_det_oe   = det_s & ~uvl_s;
		next_route    = out_en & ctrl.tx_path_select;
		next_scr      = {ctrl, diag};
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl <= `TSC_CTRL_RESET;
			diag <= 2'b00;
		end else begin
			ctrl <= next_ctrl;
			diag <= next_diag;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			prot    <= TSC_PROT_NORMAL;
			tmr     <= 32'h0;
			on_seen <= 1'b0;
		end else begin
			prot    <= next_prot;
			tmr     <= next_tmr;
			on_seen <= next_on_seen;
		end
	end

	// Tone runs free so keying starts on a clean phase
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			tone_cnt <= 16'h0;
			tone_ph  <= 1'b0;
		end else begin
			tone_cnt <= next_tone_cnt;
			tone_ph  <= next_tone_ph;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			power           <= '0;
			tone_out        <= 1'b0;
			tone_detect_oe  <= 1'b0;
			tone_detect_out <= 1'b0;
			sda_oe          <= 1'b0;
			sda_out         <= 1'b0;
			ext_mod_route   <= 1'b0;
			system_control_register <= 8'h00;
		end else begin
			power           <= next_power;
			tone_out        <= next_tone_out;
			tone_detect_oe  <= next_det_oe;
			tone_detect_out <= 1'b0;
			// Open drain: only ever pulls low
			sda_oe          <= slave_oe;
			sda_out         <= 1'b0;
			ext_mod_route   <= next_route;
			system_control_register <= next_scr;
		end
	end

	// external_modulation_in is analog; only its routing is decided here
	logic unused_ext;
	assign unused_ext = external_modulation_in;

endmodule

// File: design/tsc_params.svh
// Purpose: Constants for the tone supply control block
// Assumes: mclk at 25 MHz
// Notes:   Bit positions of the system control register, timing counts
`ifndef TSC_PARAMS_SVH
`define TSC_PARAMS_SVH

`define TSC_CLK_HZ          25000000
`define TSC_SLAVE_ADDR      7'h08
`define TSC_BIT_PULSED      7
`define TSC_BIT_TXPATH      6
`define TSC_BIT_TONE_FORCE  5
`define TSC_BIT_LINE_COMP   4
`define TSC_BIT_VOLTAGE_LEVEL_SELECT        3
`define TSC_BIT_ENABLE      2
`define TSC_BIT_OVERTEMP    1
`define TSC_BIT_OVERLOAD    0
`define TSC_CTRL_RESET      6'h00
`define TSC_OFF_MS          900
`define TSC_OFF_CYCLES      ((`TSC_CLK_HZ / 1000) * `TSC_OFF_MS)
`define TSC_ON_OFF_RATIO    10
`define TSC_TONE_HZ         22000
`define TSC_TONE_HALF       (`TSC_CLK_HZ / (2 * `TSC_TONE_HZ))

`endif

// File: design/tsc_pkg.sv
// Purpose: Types shared by the tone supply control block
// Assumes: Nothing beyond the params header
// Notes:   Control fields in register order, msb first
package tsc_pkg;

	typedef struct packed {
		logic pulsed_limit_select;
		logic tx_path_select;
		logic tone_force_on;
		logic line_drop_compensation;
		logic voltage_level_select;
		logic enable;
	} tsc_ctrl_t;

	typedef struct packed {
		logic overtemp_flag;
		logic overload_flag;
	} tsc_diag_t;

	typedef struct packed {
		logic tx_output_path;
		logic rx_output_path;
		logic converter_on;
		logic regulator_on;
		logic level_high;
		logic comp_on;
		logic comp_big_step;
	} tsc_power_t;

	typedef enum logic [1:0] {
		TSC_PROT_NORMAL,
		TSC_PROT_OFF,
		TSC_PROT_ON
	} tsc_prot_t;

	typedef enum logic [2:0] {
		TSC_I2C_IDLE,
		TSC_I2C_ADDR,
		TSC_I2C_ACK,
		TSC_I2C_WRITE,
		TSC_I2C_READ,
		TSC_I2C_RACK,
		TSC_I2C_SKIP
	} tsc_i2c_t;

endpackage

// File: design/tsc_i2c_slave.sv
// Purpose: Serial slave that writes and reads the system control register
// Assumes: scl and sda already synchronised to mclk by the caller
// Notes:   Each data byte written lands in the register; reads repeat it
`timescale 1ns/1ns
`include "tsc_params.svh"
module tsc_i2c_slave
	import tsc_pkg::*;
(
	// Clock and reset
	input  wire logic        mclk,
	input  wire logic        rst_n,
	// Synchronised bus levels
	input  wire logic        scl,
	input  wire logic        sda,
	input  wire logic        lockout,
	// Data line drive
	output logic             sda_oe,
	// Register access
	input  wire logic [7:0]  rd_data,
	output logic             wr_stb,
	output logic [7:0]       wr_data
);

	logic       scl_d;
	logic       sda_d;
	tsc_i2c_t   state;
	tsc_i2c_t   next_state;
	logic [7:0] shreg;
	logic [7:0] next_shreg;
	logic [3:0] cnt;
	logic [3:0] next_cnt;
	logic       next_sda_oe;
	logic       next_wr_stb;
	logic [7:0] next_wr_data;
	logic       rd_mode;
	logic       next_rd_mode;
	logic       scl_rise;
	logic       scl_fall;
	logic       start_c;
	logic       stop_c;

	assign scl_rise = scl & ~scl_d;
	assign scl_fall = ~scl & scl_d;
	assign start_c  = scl & scl_d & sda_d & ~sda;
	assign stop_c   = scl & scl_d & ~sda_d & sda;

	always_comb begin
		next_state   = state;
		next_shreg   = shreg;
		next_cnt     = cnt;
		next_sda_oe  = sda_oe;
		next_wr_stb  = 1'b0;
		next_wr_data = wr_data;
		next_rd_mode = rd_mode;
		if (start_c) begin
			next_state  = TSC_I2C_ADDR;
			next_cnt    = 4'h0;
			next_sda_oe = 1'b0;
		end else if (stop_c) begin
			next_state  = TSC_I2C_IDLE;
			next_sda_oe = 1'b0;
		end else begin
			case (state)
			TSC_I2C_ADDR, TSC_I2C_WRITE: begin
				if (scl_rise) begin
					next_shreg = {shreg[6:0], sda};
					next_cnt   = cnt + 4'h1;
				end
				// Ack driven from the fall after bit 8 to the next fall, so it moves only while scl low
				if (scl_fall && cnt == 4'h8) begin
					if (state == TSC_I2C_ADDR) begin
						if (shreg[7:1] == `TSC_SLAVE_ADDR && !lockout) begin
							next_sda_oe  = 1'b1;
							next_rd_mode = shreg[0];
							next_state   = TSC_I2C_ACK;
						end else begin
							next_state = TSC_I2C_SKIP;
						end
					end else begin
						next_wr_stb  = 1'b1;
						next_wr_data = shreg;
						next_sda_oe  = ~lockout;
						next_state   = TSC_I2C_ACK;
						next_rd_mode = 1'b0;
					end
				end
			end
			TSC_I2C_ACK: begin
				if (scl_fall) begin
					next_cnt = 4'h0;
					if (rd_mode) begin
						next_shreg  = {rd_data[6:0], 1'b0};
						next_sda_oe = ~rd_data[7];
						next_state  = TSC_I2C_READ;
					end else begin
						next_sda_oe = 1'b0;
						next_state  = TSC_I2C_WRITE;
					end
				end
			end
			TSC_I2C_READ: begin
				if (scl_rise) begin
					next_cnt = cnt + 4'h1;
				end
				if (scl_fall) begin
					if (cnt == 4'h8) begin
						next_sda_oe = 1'b0;
						next_state  = TSC_I2C_RACK;
					end else begin
						next_sda_oe = ~shreg[7];
						next_shreg  = {shreg[6:0], 1'b0};
					end
				end
			end
			TSC_I2C_RACK: begin
				// Master ack asks for another copy, nack ends the read
				if (scl_rise) begin
					next_state = sda ? TSC_I2C_SKIP : TSC_I2C_ACK;
				end
			end
			default: begin
				next_sda_oe = 1'b0;
			end
			endcase
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			scl_d   <= 1'b1;
			sda_d   <= 1'b1;
			state   <= TSC_I2C_IDLE;
			shreg   <= 8'h00;
			cnt     <= 4'h0;
			sda_oe  <= 1'b0;
			wr_stb  <= 1'b0;
			wr_data <= 8'h00;
			rd_mode <= 1'b0;
		end else begin
			scl_d   <= scl;
			sda_d   <= sda;
			state   <= next_state;
			shreg   <= next_shreg;
			cnt     <= next_cnt;
			sda_oe  <= next_sda_oe;
			wr_stb  <= next_wr_stb;
			wr_data <= next_wr_data;
			rd_mode <= next_rd_mode;
		end
	end

endmodule

// File: test/tsc_top_monitor.sv
// Purpose: Port checks on the tone supply block
// Assumes: Register mirror lags control by one cycle
// Notes:   Bound into the top after the module
`timescale 1ns/1ns
module tsc_top_monitor
	import tsc_pkg::*;
#(
	parameter int OFF_CYCLES = 100,
	parameter int ON_RATIO   = 10,
	parameter int TONE_HALF  = 4
)
(
	// Clock and reset
	input  wire logic       mclk,
	input  wire logic       rst_n,
	// Watched ports
	input  wire logic       scl_in,
	input  wire logic       sda_oe,
	input  wire logic       tone_detect_in,
	input  wire logic       tone_detect_oe,
	input  wire logic       overload_in,
	input  wire logic       overtemp_in,
	input  wire logic       undervoltage_in,
	input  wire tsc_power_t power,
	input  wire logic [7:0] system_control_register
);
	wire logic [7:0] r = system_control_register;
	int              hi_cnt;
	int              next_hi_cnt;
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	// Length of the current flag pulse, for the off plus on minimum
	always_comb next_hi_cnt = r[0] ? hi_cnt + 1 : 0;
	always_ff @(posedge mclk or negedge rst_n)
		if (!rst_n) hi_cnt <= 0;
		else hi_cnt <= next_hi_cnt;
	property p_det;
		$rose(tone_detect_in) |-> ##[1:5] tone_detect_oe;
	endproperty
	a_det: assert property (p_det) else $error("detector drive late");
	// Synchroniser delay: judge against the clock as the slave sees it
	property p_sda_low;
		$changed(sda_oe) |-> !$past(scl_in, 2);
	endproperty
	a_sda_low: assert property (p_sda_low) else $error("data moved, clock high");
	property p_stby;
		power != 7'h00 |-> ##[0:2] r[2];
	endproperty
	a_stby: assert property (p_stby) else $error("power on in standby");
	property p_lock_ack;
		undervoltage_in [*6] |-> !sda_oe;
	endproperty
	a_lock_ack: assert property (p_lock_ack) else $error("ack in lockout");
	property p_lock_clr;
		undervoltage_in [*6] |-> r[7:2] == 6'h00;
	endproperty
	a_lock_clr: assert property (p_lock_clr) else $error("control kept in lockout");
	property p_stat;
		(r[7] && r[2] && overload_in) [*6] |-> r[0];
	endproperty
	a_stat: assert property (p_stat) else $error("static flag missing");
	property p_ot;
		overtemp_in [*6] |-> r[1] && !power.converter_on && !power.regulator_on;
	endproperty
	a_ot: assert property (p_ot) else $error("overtemp not handled");
	property p_pulse;
		$fell(r[0]) && !r[7] && r[2] |-> hi_cnt >= OFF_CYCLES + OFF_CYCLES / ON_RATIO - 2;
	endproperty
	a_pulse: assert property (p_pulse) else $error("flag pulse short");
	c_pulse: cover property ($rose(r[0]) && !r[7]);
	c_stat: cover property ($rose(r[0]) && r[7]);
	c_lock: cover property ($rose(undervoltage_in));
endmodule
bind tsc_top tsc_top_monitor #(
	.OFF_CYCLES(OFF_CYCLES), .ON_RATIO(ON_RATIO), .TONE_HALF(TONE_HALF)
) u_mon (
	.mclk, .rst_n, .scl_in, .sda_oe, .tone_detect_in, .tone_detect_oe, .overload_in,
	.overtemp_in, .undervoltage_in, .power, .system_control_register
);

// File: test/tsc_master.sv
// Purpose: Serial master model driving the bus
// Assumes: Data line pulled up, 8 mclk a bit
// Notes:   Clock stands high between frames
`timescale 1ns/1ns
module tsc_master (
	// Clock
	input  wire logic mclk,
	// Bus
	input  wire logic sda,
	output logic      scl,
	output logic      sda_low
);
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
	end
	task automatic bit_io(input logic b, output logic r);
		scl <= 1'b0;
		repeat (2) @(posedge mclk);
		sda_low <= !b;
		repeat (2) @(posedge mclk);
		scl <= 1'b1;
		repeat (4) @(posedge mclk);
		r = sda;
	endtask
	task automatic start();
		sda_low <= 1'b1;
		repeat (4) @(posedge mclk);
	endtask
	task automatic stop();
		scl <= 1'b0;
		repeat (2) @(posedge mclk);
		sda_low <= 1'b1;
		repeat (2) @(posedge mclk);
		scl <= 1'b1;
		repeat (4) @(posedge mclk);
		sda_low <= 1'b0;
		repeat (8) @(posedge mclk);
	endtask
	task automatic xfer(input logic [7:0] w, input logic mack, output logic [7:0] rd,
		output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(w[i], r);
			rd[i] = r;
		end
		bit_io(!mack, r);
		ack = !r;
	endtask
endmodule

// File: test/tone_supply_ctrl_i2c_bench.sv
// Purpose: Self-checking bench for the tone supply block
// Assumes: 320 ns serial bit time
// Notes:   Protection and tone counts shortened by parameters
`timescale 1ns/1ns
module tone_supply_ctrl_i2c_bench;
	import tsc_pkg::*;
	logic       mclk, rst_n, key, det, ovl, ot, uv;
	logic       scl_in, sda_low, sda_out, sda_oe, tone_out, det_out, det_oe, route;
	logic [7:0] scr;
	tsc_power_t pw;
	int         errors, n_tests;
	wire logic  sda_in = !(sda_oe || sda_low);
	tsc_top #(.OFF_CYCLES(100), .ON_RATIO(10), .TONE_HALF(4)) dut (
		.mclk, .rst_n, .scl_in, .sda_in, .sda_out, .sda_oe, .tone_key_in(key),
		.tone_detect_in(det), .external_modulation_in(1'b0), .tone_out,
		.tone_detect_out(det_out), .tone_detect_oe(det_oe), .overload_in(ovl),
		.overtemp_in(ot), .undervoltage_in(uv), .power(pw), .ext_mod_route(route),
		.system_control_register(scr)
	);
	tsc_master m (.mclk, .sda(sda_in), .scl(scl_in), .sda_low);
	task automatic step(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask
	task automatic chk(input logic [7:0] s, input logic [7:0] e);
		n_tests++;
		if (s !== e) begin
			errors++;
			$display("unexpected at %0t: %h not %h", $time, s, e);
		end
	endtask
	task automatic test_done();
		if (errors == 0 && n_tests > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	task automatic wt(input int b, input logic v);
		int i;
		for (i = 0; i < 400 && scr[b] !== v; i++) step(1);
		if (i == 400) begin
			errors++;
			$display("unexpected at %0t: wait ran out", $time);
			test_done();
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic k);
		logic [7:0] x;
		logic       kd;
		m.start();
		m.xfer(a, 1'b0, x, k);
		m.xfer(d, 1'b0, x, kd);
		m.stop();
		step(4);
	endtask
	task automatic rd(output logic [7:0] v);
		logic k;
		m.start();
		m.xfer(8'h11, 1'b0, v, k);
		m.xfer(8'hff, 1'b0, v, k);
		m.stop();
	endtask
	// Period of four cycles a half gives twenty edges in eighty cycles
	task automatic tc(input logic [7:0] e);
		logic p;
		int   n;
		n = 0;
		p = tone_out;
		repeat (80) begin
			step(1);
			if (tone_out !== p) n++;
			p = tone_out;
		end
		chk(n[7:0], e);
	endtask
	task automatic t_regs();
		logic [7:0] v;
		logic       k;
		logic [7:0] d[4] = '{8'hff, 8'h14, 8'h04, 8'h00};
		logic [6:0] p[4] = '{7'h5f, 7'h3a, 7'h38, 7'h00};
		chk(scr, 8'h00);
		for (int i = 0; i < 4; i++) begin
			wr(8'h10, d[i], k);
			chk({7'h00, k}, 8'h01);
			chk({1'b0, pw}, {1'b0, p[i]});
			chk({7'h00, route}, {7'h00, d[i][6] & d[i][2]});
			rd(v);
			chk(v, d[i] & 8'hfc);
		end
		wr(8'h12, 8'h04, k);
		chk({7'h00, k}, 8'h00);
		chk(scr, 8'h00);
	endtask
	task automatic t_tone();
		logic k;
		wr(8'h10, 8'h24, k);
		tc(8'h14);
		wr(8'h10, 8'h04, k);
		tc(8'h00);
		key <= 1'b1;
		step(8);
		tc(8'h14);
		wr(8'h10, 8'h00, k);
		tc(8'h00);
		key <= 1'b0;
		det <= 1'b1;
		step(6);
		chk({6'h00, det_oe, det_out}, 8'h02);
		det <= 1'b0;
		step(6);
		chk({6'h00, det_oe, det_out}, 8'h00);
		chk({7'h00, sda_out}, 8'h00);
	endtask
	task automatic t_prot();
		logic k;
		wr(8'h10, 8'h04, k);
		ovl <= 1'b1;
		wt(0, 1'b1);
		step(2);
		chk({7'h00, pw.rx_output_path}, 8'h00);
		step(150);
		chk(scr, 8'h05);
		ovl <= 1'b0;
		wt(0, 1'b0);
		chk({1'b0, pw}, 8'h38);
		// Capacitive start goes static first
		wr(8'h10, 8'h84, k);
		ovl <= 1'b1;
		step(8);
		chk(scr, 8'h85);
		chk({1'b0, pw}, 8'h38);
		ovl <= 1'b0;
		wt(0, 1'b0);
		ot <= 1'b1;
		wt(1, 1'b1);
		step(2);
		chk({6'h00, pw.converter_on, pw.regulator_on}, 8'h00);
		ot <= 1'b0;
		wt(1, 1'b0);
		uv <= 1'b1;
		step(8);
		chk(scr, 8'h00);
		wr(8'h10, 8'h04, k);
		chk({7'h00, k}, 8'h00);
		uv <= 1'b0;
		step(4);
		wr(8'h10, 8'h04, k);
		chk({7'h00, k}, 8'h01);
	endtask
	initial begin
		mclk = 1'b0;
		forever #20 mclk = !mclk;
	end
	initial begin
		{rst_n, key, det, ovl, ot, uv} = 6'h00;
		errors = 0;
		n_tests = 0;
		step(4);
		rst_n <= 1'b1;
		step(4);
		t_regs();
		t_tone();
		t_prot();
		test_done();
	end
endmodule
